// ===== hdl/sio_sram_pkg.sv
/*
 * shared constants, state encodings and the function list of the separate-I/O
 * two-word burst SRAM port.
 * assumes a single reference clock that oversamples every link clock.
 */
// Function
// - each access moves exactly two data words in one link clock period
// - with load low, direction high means read and low means write
// - address is captured on rising primary_timing_pos during reads and writes
// - one shared address bus carries both read and write addresses
// - address width is 22 bits for x8/x9, 21 for x18, 20 for x36
// - storage is two equal arrays, one address selects a two-word location
// - address inputs are ignored when no access is loaded
// - x8 nibble selects sampled on both clock rises, bit0 [3:0], bit1 [7:4]
// - each nibble select is captured on the same edge as its data word
// - a high nibble select discards that nibble, stored nibble unchanged
// - byte selects sampled on both clock rises, each gating its 9-bit lane except in x8, where they are ignored
// - byte selects 0 to 3 map to lanes [8:0] [17:9] [26:18] [35:27]
// - a high byte select ignores that lane, stored byte unaltered
// - read data leaves on the output timing clock pair when supplied
// - write data sampled on rises of both primary clocks, one word per edge
// - every access starts only on a rising edge of primary_timing_pos
// - without output timing clocks, read data follows the primary clocks
package sio_sram_pkg;
    localparam int ADDR_W      = 22;
    localparam int DATA_W      = 36;
    localparam int LANE_W      = 9;
    localparam int LANES       = 4;
    localparam int NIB_W       = 4;
    localparam int NIBS        = 2;
    localparam int BURST       = 2;
    localparam int STORE_IDX_W = 10;
    localparam int STORE_DEPTH = 1 << STORE_IDX_W;

    localparam logic [1:0] CFG_X8  = 2'h0;
    localparam logic [1:0] CFG_X9  = 2'h1;
    localparam logic [1:0] CFG_X18 = 2'h2;
    localparam logic [1:0] CFG_X36 = 2'h3;

    localparam logic [ADDR_W-1:0] ADDR_MASK_X8  = 22'h3FFFFF;
    localparam logic [ADDR_W-1:0] ADDR_MASK_X9  = 22'h3FFFFF;
    localparam logic [ADDR_W-1:0] ADDR_MASK_X18 = 22'h1FFFFF;
    localparam logic [ADDR_W-1:0] ADDR_MASK_X36 = 22'h0FFFFF;

    localparam logic [DATA_W-1:0] DATA_MASK_X8  = 36'h0000000FF;
    localparam logic [DATA_W-1:0] DATA_MASK_X9  = 36'h0000001FF;
    localparam logic [DATA_W-1:0] DATA_MASK_X18 = 36'h00003FFFF;
    localparam logic [DATA_W-1:0] DATA_MASK_X36 = 36'hFFFFFFFFF;

    localparam logic [DATA_W-1:0] READ_RESET = 36'h000000000;

    typedef enum logic [1:0] {
        W_IDLE  = 2'h0,
        W_WORD0 = 2'h1,
        W_WORD1 = 2'h3
    } wr_state_t;

    typedef enum logic [1:0] {
        R_IDLE  = 2'h0,
        R_WORD0 = 2'h1,
        R_WORD1 = 2'h3
    } rd_state_t;
endpackage

// ===== hdl/sram_store_if.sv
/*
 * bundle between the port control and its two-array word store.
 * assumes both ends run on the reference clock.
 */
interface sram_store_if;
    logic                                   ce;
    logic                                   wr_en;
    logic                                   wr_sel;
    logic [sio_sram_pkg::STORE_IDX_W-1:0]   wr_idx;
    logic [sio_sram_pkg::DATA_W-1:0]        wr_data;
    logic [sio_sram_pkg::DATA_W-1:0]        wr_mask;
    logic                                   rd_en;
    logic [sio_sram_pkg::STORE_IDX_W-1:0]   rd_idx;
    logic [sio_sram_pkg::DATA_W-1:0]        rd_word [sio_sram_pkg::BURST];

    modport ctrl (
        output ce, wr_en, wr_sel, wr_idx, wr_data, wr_mask, rd_en, rd_idx,
        input  rd_word
    );
    modport store (
        input  ce, wr_en, wr_sel, wr_idx, wr_data, wr_mask, rd_en, rd_idx,
        output rd_word
    );
endinterface

// ===== hdl/burst_word_store.sv
/*
 * two equal word arrays; one index selects a two-word location.
 * assumes writes carry a per-bit mask and reads are registered.
 */
module burst_word_store (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    sram_store_if.store     sif
);
    // ------------------------------------------------------------------
    // one array per burst word
    // ------------------------------------------------------------------
    for (genvar w = 0; w < sio_sram_pkg::BURST; w++) begin : g_array
        logic [sio_sram_pkg::DATA_W-1:0] arr [sio_sram_pkg::STORE_DEPTH];
        logic [sio_sram_pkg::DATA_W-1:0] rd_q;

        always_ff @(posedge i_ref_clk) begin
            if (sif.ce && sif.wr_en && sif.wr_sel == 1'(w)) begin
                // masked bits keep their old value
                arr[sif.wr_idx] <= (arr[sif.wr_idx] & ~sif.wr_mask)
                                 | (sif.wr_data & sif.wr_mask);
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (i_reset) begin
                rd_q <= sio_sram_pkg::READ_RESET;
            end else if (sif.ce && sif.rd_en) begin
                rd_q <= arr[sif.rd_idx];
            end
        end

        assign sif.rd_word[w] = rd_q;
    end
endmodule

// ===== hdl/sio_burst_sram_port_control.sv
/*
 * device-side control of a separate-I/O double-data-rate burst SRAM port:
 * load and direction decode, shared address capture, per-lane write masks,
 * and read data timed by the output or primary clock pair.
 * assumes all link pins are asynchronous to i_ref_clk and slow enough that
 * each link clock level lasts several reference cycles.
 */
module sio_burst_sram_port_control (
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_reset,
    input  wire logic                              i_clk_en,
    input  wire logic [1:0]                        i_word_config,
    input  wire logic                              i_primary_timing_pos,
    input  wire logic                              i_primary_timing_neg,
    input  wire logic                              i_read_out_timing_pos,
    input  wire logic                              i_read_out_timing_neg,
    input  wire logic                              i_out_clocks_used,
    input  wire logic                              i_bus_cycle_load_n,
    input  wire logic                              i_access_direction,
    input  wire logic [sio_sram_pkg::ADDR_W-1:0]   i_address,
    input  wire logic [sio_sram_pkg::DATA_W-1:0]   i_write_input_bits,
    input  wire logic [sio_sram_pkg::NIBS-1:0]     i_nibble_write_sel_n,
    input  wire logic [sio_sram_pkg::LANES-1:0]    i_byte_write_sel_n,
    output logic      [sio_sram_pkg::DATA_W-1:0]   o_returning_output_bits
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                                  k_s1, k_s2, k_prev;
        logic                                  kn_s1, kn_s2, kn_prev;
        logic                                  c_s1, c_s2, c_prev;
        logic                                  cn_s1, cn_s2, cn_prev;
        logic                                  sel_s1, sel_s2;
        logic [1:0]                            cfg_s1, cfg_s2;
        logic                                  ld_s1, ld_s2;
        logic                                  dir_s1, dir_s2;
        logic [sio_sram_pkg::ADDR_W-1:0]       addr_s1, addr_s2;
        logic [sio_sram_pkg::DATA_W-1:0]       d_s1, d_s2;
        logic [sio_sram_pkg::NIBS-1:0]         nws_s1, nws_s2;
        logic [sio_sram_pkg::LANES-1:0]        bws_s1, bws_s2;
        logic [sio_sram_pkg::ADDR_W-1:0]       cap_addr;
        sio_sram_pkg::wr_state_t               wst;
        logic [sio_sram_pkg::STORE_IDX_W-1:0]  wr_idx;
        sio_sram_pkg::rd_state_t               rst_fsm;
        logic                                  rd_pend;
        logic [sio_sram_pkg::DATA_W-1:0]       hold1;
        logic [sio_sram_pkg::DATA_W-1:0]       q;
    } state_t;

    state_t s;
    state_t next_s;

    sram_store_if sif ();

    // ------------------------------------------------------------------
    // edge and command decode
    // ------------------------------------------------------------------
    logic                                k_rise;
    logic                                kn_rise;
    logic                                out_pos_rise;
    logic                                out_neg_rise;
    logic                                load;
    logic                                rd_load;
    logic                                wr_load;
    logic [sio_sram_pkg::ADDR_W-1:0]     addr_mask;
    logic [sio_sram_pkg::ADDR_W-1:0]     addr_eff;
    logic [sio_sram_pkg::DATA_W-1:0]     data_mask;
    logic [sio_sram_pkg::DATA_W-1:0]     wmask;
    logic                                wr_en_c;
    logic                                wr_sel_c;
    logic                                rd_en_c;

    assign k_rise  = s.k_s2 & ~s.k_prev;
    assign kn_rise = s.kn_s2 & ~s.kn_prev;
    // output pair when supplied, else the primary pair
    assign out_pos_rise = s.sel_s2 ? (s.c_s2 & ~s.c_prev) : k_rise;
    assign out_neg_rise = s.sel_s2 ? (s.cn_s2 & ~s.cn_prev)
                                   : kn_rise;
    // accesses begin on a primary positive rise only
    assign load    = k_rise & ~s.ld_s2;
    assign rd_load = load & s.dir_s2;
    assign wr_load = load & ~s.dir_s2;

    always_comb begin
        case (s.cfg_s2)
            sio_sram_pkg::CFG_X8: begin
                addr_mask = sio_sram_pkg::ADDR_MASK_X8;
                data_mask = sio_sram_pkg::DATA_MASK_X8;
            end
            sio_sram_pkg::CFG_X9: begin
                addr_mask = sio_sram_pkg::ADDR_MASK_X9;
                data_mask = sio_sram_pkg::DATA_MASK_X9;
            end
            sio_sram_pkg::CFG_X18: begin
                addr_mask = sio_sram_pkg::ADDR_MASK_X18;
                data_mask = sio_sram_pkg::DATA_MASK_X18;
            end
            default: begin
                addr_mask = sio_sram_pkg::ADDR_MASK_X36;
                data_mask = sio_sram_pkg::DATA_MASK_X36;
            end
        endcase
    end

    // one address bus serves both ports
    assign addr_eff = s.addr_s2 & addr_mask;

    // ------------------------------------------------------------------
    // per-bit write enables from the lane selects
    // ------------------------------------------------------------------
    for (genvar b = 0; b < sio_sram_pkg::DATA_W; b++) begin : g_mask
        if (b < sio_sram_pkg::NIBS * sio_sram_pkg::NIB_W) begin : g_low
            assign wmask[b] = (s.cfg_s2 == sio_sram_pkg::CFG_X8)
                ? ~s.nws_s2[b / sio_sram_pkg::NIB_W]
                : (data_mask[b]
                   & ~s.bws_s2[b / sio_sram_pkg::LANE_W]);
        end else begin : g_high
            assign wmask[b] = (s.cfg_s2 != sio_sram_pkg::CFG_X8)
                & data_mask[b]
                & ~s.bws_s2[b / sio_sram_pkg::LANE_W];
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s   = s;
        wr_en_c  = 1'b0;
        wr_sel_c = 1'b0;
        rd_en_c  = 1'b0;
        if (i_clk_en) begin
            next_s.k_s1    = i_primary_timing_pos;
            next_s.k_s2    = s.k_s1;
            next_s.k_prev  = s.k_s2;
            next_s.kn_s1   = i_primary_timing_neg;
            next_s.kn_s2   = s.kn_s1;
            next_s.kn_prev = s.kn_s2;
            next_s.c_s1    = i_read_out_timing_pos;
            next_s.c_s2    = s.c_s1;
            next_s.c_prev  = s.c_s2;
            next_s.cn_s1   = i_read_out_timing_neg;
            next_s.cn_s2   = s.cn_s1;
            next_s.cn_prev = s.cn_s2;
            next_s.sel_s1  = i_out_clocks_used;
            next_s.sel_s2  = s.sel_s1;
            next_s.cfg_s1  = i_word_config;
            next_s.cfg_s2  = s.cfg_s1;
            next_s.ld_s1   = i_bus_cycle_load_n;
            next_s.ld_s2   = s.ld_s1;
            next_s.dir_s1  = i_access_direction;
            next_s.dir_s2  = s.dir_s1;
            next_s.addr_s1 = i_address;
            next_s.addr_s2 = s.addr_s1;
            next_s.d_s1    = i_write_input_bits;
            next_s.d_s2    = s.d_s1;
            next_s.nws_s1  = i_nibble_write_sel_n;
            next_s.nws_s2  = s.nws_s1;
            next_s.bws_s1  = i_byte_write_sel_n;
            next_s.bws_s2  = s.bws_s1;

            // address only taken when an access is loaded
            if (load) begin
                next_s.cap_addr = addr_eff;
            end

            // write burst: word0 on the negative rise, word1 on the next
            // positive rise, masks taken with the same edge as the data
            case (s.wst)
                sio_sram_pkg::W_IDLE: begin
                    if (wr_load) begin
                        next_s.wst    = sio_sram_pkg::W_WORD0;
                        next_s.wr_idx = addr_eff[sio_sram_pkg::STORE_IDX_W-1:0];
                    end
                end
                sio_sram_pkg::W_WORD0: begin
                    if (kn_rise) begin
                        wr_en_c    = 1'b1;
                        next_s.wst = sio_sram_pkg::W_WORD1;
                    end
                end
                sio_sram_pkg::W_WORD1: begin
                    if (k_rise) begin
                        wr_en_c  = 1'b1;
                        wr_sel_c = 1'b1;
                        if (wr_load) begin
                            next_s.wst    = sio_sram_pkg::W_WORD0;
                            next_s.wr_idx =
                                addr_eff[sio_sram_pkg::STORE_IDX_W-1:0];
                        end else begin
                            next_s.wst = sio_sram_pkg::W_IDLE;
                        end
                    end
                end
                default: next_s.wst = sio_sram_pkg::W_IDLE;
            endcase

            // read burst: fetch both words, word0 on the negative output
            // rise, word1 on the next positive output rise
            case (s.rst_fsm)
                sio_sram_pkg::R_IDLE: begin
                    if (rd_load) begin
                        rd_en_c        = 1'b1;
                        next_s.rst_fsm = sio_sram_pkg::R_WORD0;
                    end
                end
                sio_sram_pkg::R_WORD0: begin
                    // refetch so a word written at the load edge is seen
                    rd_en_c = 1'b1;
                    if (out_neg_rise) begin
                        next_s.q       = sif.rd_word[0] & data_mask;
                        next_s.hold1   = sif.rd_word[1] & data_mask;
                        next_s.rst_fsm = sio_sram_pkg::R_WORD1;
                    end
                end
                sio_sram_pkg::R_WORD1: begin
                    if (rd_load) begin
                        rd_en_c        = 1'b1;
                        next_s.rd_pend = 1'b1;
                    end
                    if (out_pos_rise) begin
                        next_s.q       = s.hold1;
                        next_s.rd_pend = 1'b0;
                        next_s.rst_fsm = (s.rd_pend || rd_load)
                                       ? sio_sram_pkg::R_WORD0
                                       : sio_sram_pkg::R_IDLE;
                    end
                end
                default: next_s.rst_fsm = sio_sram_pkg::R_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // store hookup and outputs
    // ------------------------------------------------------------------
    assign sif.ce      = i_clk_en;
    assign sif.wr_en   = wr_en_c;
    assign sif.wr_sel  = wr_sel_c;
    assign sif.wr_idx  = s.wr_idx;
    assign sif.wr_data = s.d_s2;
    assign sif.wr_mask = wmask;
    assign sif.rd_en   = rd_en_c;
    // a pending burst reads from the captured address
    assign sif.rd_idx  = (s.rst_fsm == sio_sram_pkg::R_WORD0)
                       ? s.cap_addr[sio_sram_pkg::STORE_IDX_W-1:0]
                       : addr_eff[sio_sram_pkg::STORE_IDX_W-1:0];

    burst_word_store u_store (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .sif       (sif)
    );

    assign o_returning_output_bits = s.q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_write_load_dir: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        i_clk_en && wr_load && s.wst == sio_sram_pkg::W_IDLE
        |=> s.wst == sio_sram_pkg::W_WORD0)
        else $error("write load did not open a write burst");

    a_read_load_dir: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        i_clk_en && rd_load && s.rst_fsm == sio_sram_pkg::R_IDLE
        |-> rd_en_c ##1 s.rst_fsm == sio_sram_pkg::R_WORD0)
        else $error("read load did not fetch a burst");

    a_addr_capture: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        i_clk_en && load |=> s.cap_addr == $past(addr_eff))
        else $error("loaded address not captured");

    a_addr_ignored: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        !load |=> $stable(s.cap_addr))
        else $error("address taken without a load");

    a_addr_width: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        s.cfg_s2 == sio_sram_pkg::CFG_X36 && load
        |=> s.cap_addr[21:20] == 2'h0)
        else $error("address wider than configuration");

    a_burst_two_words: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        i_clk_en && wr_load && s.wst == sio_sram_pkg::W_IDLE
        |-> ##[1:40] (wr_en_c && !wr_sel_c) ##[1:40] (wr_en_c && wr_sel_c))
        else $error("write burst did not store two words");

    a_nibble_mask: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        wr_en_c && s.cfg_s2 == sio_sram_pkg::CFG_X8
        |-> wmask[7:4] == {4{~s.nws_s2[1]}} && wmask[35:8] == 28'h0000000)
        else $error("nibble mask lane mismatch");

    a_byte_mask: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        wr_en_c && s.cfg_s2 == sio_sram_pkg::CFG_X36
        |-> wmask[35:27] == {9{~s.bws_s2[3]}}
            && wmask[17:9] == {9{~s.bws_s2[1]}})
        else $error("byte mask lane mismatch");

    a_word1_out: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        i_clk_en && s.rst_fsm == sio_sram_pkg::R_WORD1 && out_pos_rise
        |=> o_returning_output_bits == $past(s.hold1))
        else $error("second read word not driven on output rise");

    a_single_clock: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        !s.sel_s2 |-> out_neg_rise == kn_rise)
        else $error("single clock mode not following primary clocks");
endmodule

// ===== sim/sram_ctrl_model.sv
/*
 * controller-side model of the separate-I/O burst SRAM link: link clocks,
 * skewed output clocks, load, direction, address, write data and masks.
 * assumes requests are queued through send and i_ref_clk oversamples links.
 */
module sram_ctrl_model (
    input  wire logic                            i_ref_clk,
    output logic                                 o_link_pos,
    output logic                                 o_link_neg,
    output logic                                 o_out_pos,
    output logic                                 o_out_neg,
    output logic                                 o_load_n,
    output logic                                 o_dir,
    output logic [sio_sram_pkg::ADDR_W-1:0]      o_addr,
    output logic [sio_sram_pkg::DATA_W-1:0]      o_data,
    output logic [1:0]                           o_nib_n,
    output logic [3:0]                           o_bws_n
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic dir;
        logic [21:0] a;
        logic [35:0] d0, d1;
        logic [1:0] n0, n1;
        logic [3:0] b0, b1;
    } req_t;
    req_t q [$];
    req_t cur;
    req_t nxt;
    logic link_q = 1'b0;
    logic wr_busy = 1'b0;
    int   rd_loaded = 0;

    // ------------------------------------------------------------
    // free-running link clock, complementary and skewed copies
    // ------------------------------------------------------------
    initial begin
        o_link_pos = 1'b0;
        o_out_pos = 1'b0;
        o_out_neg = 1'b1;
        #1.3;
        forever #40 o_link_pos = ~o_link_pos;
    end
    assign o_link_neg = ~o_link_pos;
    always @(o_link_pos) begin
        o_out_pos <= #20 o_link_pos;
        o_out_neg <= #20 ~o_link_pos;
    end

    // ------------------------------------------------------------
    // request sequencing, changed just after the link edges
    // ------------------------------------------------------------
    task automatic send(input logic dir, input logic [21:0] a,
                        input logic [35:0] d0, input logic [35:0] d1,
                        input logic [1:0] n0, input logic [1:0] n1,
                        input logic [3:0] b0, input logic [3:0] b1);
        q.push_back({dir, a, d0, d1, n0, n1, b0, b1});
    endtask
    initial begin
        o_load_n = 1'b1;
        o_dir = 1'b0;
        o_addr = '0;
        o_data = '0;
        o_nib_n = 2'h3;
        o_bws_n = 4'hF;
    end
    always @(posedge i_ref_clk) begin
        link_q <= o_link_pos;
        if (o_link_pos && !link_q) begin
            wr_busy = !o_load_n && !nxt.dir;
            if (!o_load_n) begin
                cur = nxt;
                rd_loaded += int'(nxt.dir);
            end
            o_load_n <= 1'b1;
            o_dir <= ~o_dir;
            o_addr <= ~o_addr;
            o_data <= wr_busy ? cur.d0 : ~o_data;
            o_nib_n <= wr_busy ? cur.n0 : 2'h3;
            o_bws_n <= wr_busy ? cur.b0 : 4'hF;
        end else if (!o_link_pos && link_q) begin
            o_data <= wr_busy ? cur.d1 : ~o_data;
            o_nib_n <= wr_busy ? cur.n1 : 2'h3;
            o_bws_n <= wr_busy ? cur.b1 : 4'hF;
            if (q.size() > 0) begin
                nxt = q.pop_front();
                o_load_n <= 1'b0;
                o_dir <= nxt.dir;
                o_addr <= nxt.a;
            end
        end
    end
endmodule

// ===== sim/testbench.sv
/*
 * self-checking bench: queued bursts through the controller model, a bench
 * copy of the store, and a monitor comparing read words at the output or primary clocks.
 * assumes the design and the controller model compiled before it.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_ref_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_out_clocks_used = 1'b0;
    logic [1:0]  i_word_config = 2'h3;
    logic        link_pos, link_neg, out_pos, out_neg, load_n, dir;
    logic [21:0] addr;
    logic [35:0] data, o_returning_output_bits;
    logic [1:0]  nib_n;
    logic [3:0]  bws_n;
    logic [35:0] mem [1024][2];
    logic [35:0] exp_q [$];
    logic [35:0] dm [4] = '{sio_sram_pkg::DATA_MASK_X8,
        sio_sram_pkg::DATA_MASK_X9, sio_sram_pkg::DATA_MASK_X18,
        sio_sram_pkg::DATA_MASK_X36};
    logic [21:0] am [4] = '{sio_sram_pkg::ADDR_MASK_X8,
        sio_sram_pkg::ADDR_MASK_X9, sio_sram_pkg::ADDR_MASK_X18,
        sio_sram_pkg::ADDR_MASK_X36};
    logic [3:0]  bfree [4] = '{4'hF, 4'hE, 4'hC, 4'h0};
    logic [1:0]  nfree [4] = '{2'h0, 2'h3, 2'h3, 2'h3};
    int          errors = 0;
    int          num_checks = 0;
    int          rd_done = 0;
    integer      seed = 32'h335C8CD6;
    wire sel_neg = i_out_clocks_used ? out_neg : link_neg;
    wire sel_pos = i_out_clocks_used ? out_pos : link_pos;
    always #2.5 i_ref_clk = ~i_ref_clk;

    sio_burst_sram_port_control i_dut (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .i_clk_en(1'b1), .i_word_config(i_word_config),
        .i_primary_timing_pos(link_pos), .i_primary_timing_neg(link_neg),
        .i_read_out_timing_pos(out_pos), .i_read_out_timing_neg(out_neg),
        .i_out_clocks_used(i_out_clocks_used), .i_bus_cycle_load_n(load_n),
        .i_access_direction(dir), .i_address(addr),
        .i_write_input_bits(data), .i_nibble_write_sel_n(nib_n),
        .i_byte_write_sel_n(bws_n),
        .o_returning_output_bits(o_returning_output_bits));
    sram_ctrl_model i_model (.i_ref_clk(i_ref_clk), .o_link_pos(link_pos),
        .o_link_neg(link_neg), .o_out_pos(out_pos), .o_out_neg(out_neg),
        .o_load_n(load_n), .o_dir(dir), .o_addr(addr), .o_data(data),
        .o_nib_n(nib_n), .o_bws_n(bws_n));

    // ------------------------------------------------------------
    // compare, verdict, one burst with its expectation
    // ------------------------------------------------------------
    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH %0t read %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic op(input logic rd, input logic full, input logic [9:0] ix);
        logic [35:0] d [2];
        logic [1:0]  n [2];
        logic [3:0]  b [2];
        logic [35:0] m;
        logic [21:0] a;
        a = 22'({$random(seed), ix}) & am[i_word_config];
        for (int k = 0; k < 2; k++) begin
            d[k] = 36'({$random(seed), $random(seed)});
            n[k] = (full ? 2'h0 : 2'($random(seed))) | nfree[i_word_config];
            b[k] = (full ? 4'h0 : 4'($random(seed))) | bfree[i_word_config];
            m = (i_word_config == 2'h0) ? {28'h0, {4{~n[k][1]}}, {4{~n[k][0]}}}
                : {{9{~b[k][3]}}, {9{~b[k][2]}}, {9{~b[k][1]}}, {9{~b[k][0]}}};
            if (rd) begin
                exp_q.push_back(mem[ix][k] & dm[i_word_config]);
            end else begin
                mem[ix][k] = (mem[ix][k] & ~m) | (d[k] & m);
            end
        end
        i_model.send(rd, a, d[0], d[1], n[0], n[1], b[0], b[1]);
    endtask

    // ------------------------------------------------------------
    // read word monitor: word0 at output neg rise, word1 at pos rise
    // ------------------------------------------------------------
    always @(posedge sel_neg) begin
        if (i_model.rd_loaded > rd_done) begin
            rd_done++;
            repeat (5) @(posedge i_ref_clk);
            check(o_returning_output_bits, exp_q.pop_front());
            @(posedge sel_pos);
            repeat (5) @(posedge i_ref_clk);
            check(o_returning_output_bits, exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // every word config, both output clock modes, mixed bursts
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        check(o_returning_output_bits, sio_sram_pkg::READ_RESET);
        for (int c = 3; c >= 0; c--) begin
            i_word_config <= 2'(c);
            i_out_clocks_used <= c[0];
            repeat (20) @(posedge i_ref_clk);
            for (int i = 0; i < 4; i++) begin
                op(1'b0, 1'b1, 10'(c * 8 + i));
            end
            for (int i = 0; i < 4; i++) begin
                op(1'b0, 1'b0, 10'(c * 8 + i));
                op(1'b1, 1'b0, 10'(c * 8 + i));
            end
            for (int t = 0; t < 3000 && exp_q.size() > 0; t++) begin
                @(posedge i_ref_clk);
            end
            if (exp_q.size() > 0) begin
                errors++;
                $display("MISMATCH %0t reads still pending", $time);
                break;
            end
        end
        wrap_up();
    end
endmodule
